/* design/slb_regs.sv */
// Link bridge control and status register group of the serializer
//
// Contract
// RQ1: freeze blocks capability auto-update
// RQ2: bit 5 sends frequency training
// RQ3: bit 4 sends equalizer training
// RQ4: bit 3 holds dual-link support
// RQ5: bit 2 gives primary/secondary channel
// RQ6: bit 1 wide video with sound
// RQ7: bit 0 forward-frame GPIO support
// RQ8: bits 1,0 auto-fill after lock
// RQ9: software overwriting caps sets freeze
// RQ10: timeout without traffic drops link detect
// RQ11: timeout codes 325,162,650us,1.3ms
// RQ12: target codes: config data, die identifier
// RQ13: auto-increment address after each access
// RQ14: start bit launches indirect read
// RQ15: start bit self-clears when done
// RQ16: software writes address before start
// RQ17: indirect access needs enable bit
// RQ18: bitmap select, reset from strap one
// RQ19: pixel mode, reset from strap zero
// RQ20: swap selects secondary or exchanges ports
// RQ21: reload bit clears after load
// RQ22: address and data bytes, reset zero
// RQ23: per-port copies by port select
// RQ24: reserved bits read zero
`timescale 1ns/10ps
module slb_regs #(
   parameter logic [7:0] DIE_ID_BASE = 8'h5A
) (
   input wire logic clock,
   input wire logic rstn,
   input slb_pkg::slb_req_t req,
   output logic [7:0] rdata,
   input wire logic second_port_select,
   input wire logic strap_select_zero,
   input wire logic strap_select_one,
   input wire logic rx_lock,
   input wire logic backchannel_valid,
   input slb_pkg::slb_caps_t remote_caps,
   output logic link_detect,
   output slb_pkg::slb_video_t video,
   output logic cfg_loading
);

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [2:0] {
      ST_STRAP = 3'b001,
      ST_RUN = 3'b010,
      ST_LOAD = 3'b100
   } slb_phase_t;

   typedef struct packed {
      slb_phase_t  phase;
      logic [7:0]  cap0;
      logic [7:0]  cap1;
      logic [7:0]  link;
      logic [7:0]  ind_ctl;
      logic [7:0]  ind_adr;
      logic [7:0]  ind_dat;
      logic [7:0]  bridge;
      logic [4:0]  load_cnt;
      logic [7:0]  rdata;
      slb_pkg::slb_video_t video;
      logic        detect;
      logic        loading;
   } slb_state_t;

   slb_state_t state;
   slb_state_t next_state;

   // Strap and remote inputs come from other domains
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic ind_busy;
   logic ind_done;
   logic [7:0] ind_rdata;
   logic timer_detect;
   logic ind_start;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end else begin
         sync1 <= {strap_select_one, strap_select_zero, rx_lock};
         sync2 <= sync1;
      end
   end

   // Mask of a written byte; bits outside the mask become zero
   function automatic logic [7:0] wmask(input logic [7:0] d, input logic [7:0] m);
      wmask = d & m;
   endfunction

   // ****************************************
   // Sub-blocks
   // ****************************************
   // RQ17: read only while enabled
   assign ind_start = state.ind_ctl[slb_pkg::IND_READ] & state.ind_ctl[slb_pkg::IND_ENABLE]
                      & ~ind_busy & ~ind_done;

   slb_indirect #(.DIE_ID_BASE(DIE_ID_BASE)) u_ind (
      .clock(clock),
      .rstn(rstn),
      .start(ind_start),
      .target(state.ind_ctl[4:3]),
      .addr(state.ind_adr),
      .busy(ind_busy),
      .done(ind_done),
      .rdata(ind_rdata)
   );

   // RQ11: timeout selection
   slb_link_timer u_timer (
      .clock(clock),
      .rstn(rstn),
      .timeout_sel(state.link[1:0]),
      .valid_rx(backchannel_valid),
      .link_detect(timer_detect)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   logic [7:0] cap_sel;
   logic [7:0] next_cap;
   always_comb begin
      next_state = state;
      cap_sel = second_port_select ? state.cap1 : state.cap0;
      next_cap = cap_sel;
      next_state.detect = timer_detect;

      // RQ18: straps caught after release
      if (state.phase == slb_phase_t'(3'h0)) begin
         next_state.phase = ST_RUN;
      end
      case (state.phase)
         ST_STRAP: begin
            // Synchroniser restarts from zero, so wait until it holds the pins
            if (state.load_cnt == 5'(slb_pkg::STRAP_SYNC_CYC)) begin
               next_state.bridge[slb_pkg::BR_MAPSEL] = sync2[2];
               // RQ19: pixel mode from strap
               next_state.bridge[slb_pkg::BR_PIXMODE] = sync2[1];
               next_state.phase = ST_RUN;
            end else begin
               next_state.load_cnt = state.load_cnt + 5'h01;
            end
         end
         ST_RUN: begin
            if (state.bridge[slb_pkg::BR_CFG_INIT]) begin
               next_state.phase = ST_LOAD;
               next_state.load_cnt = 5'h00;
            end
         end
         ST_LOAD: begin
            // RQ21: reload clears bit
            if (state.load_cnt == 5'(slb_pkg::CFG_LOAD_CYC - 1)) begin
               next_state.bridge[slb_pkg::BR_CFG_INIT] = 1'b0;
               next_state.phase = ST_RUN;
            end else begin
               next_state.load_cnt = state.load_cnt + 5'h01;
            end
         end
         default: next_state.phase = ST_RUN;
      endcase

      // RQ8: auto-fill after lock
      // RQ1: frozen caps untouched
      if (sync2[0] && remote_caps.valid && !cap_sel[slb_pkg::CAP_FREEZE]) begin
         // RQ4: dual-link support bit
         next_cap[slb_pkg::CAP_DUAL_LINK] = remote_caps.dual_link;
         // RQ5: channel role bit
         next_cap[slb_pkg::CAP_DUAL_CHAN] = remote_caps.dual_chan;
         // RQ6: wide video with sound
         next_cap[slb_pkg::CAP_WIDE_VIDEO] = remote_caps.wide_video;
         // RQ7: forward-frame GPIO bit
         next_cap[slb_pkg::CAP_FWD_GPIO] = remote_caps.fwd_gpio;
      end

      // RQ13: auto-increment after read
      if (ind_done) begin
         next_state.ind_dat = ind_rdata;
         // RQ15: start bit self-clears
         next_state.ind_ctl[slb_pkg::IND_READ] = 1'b0;
         if (state.ind_ctl[slb_pkg::IND_AUTO_INC]) begin
            next_state.ind_adr = state.ind_adr + 8'h01;
         end
      end

      // RQ24: masked register writes
      if (req.write) begin
         case (req.addr)
            // RQ23: port-select steers copy
            slb_pkg::OFS_CAP: next_cap = wmask(req.wdata, slb_pkg::MASK_CAP);
            slb_pkg::OFS_LINK: next_state.link = wmask(req.wdata, slb_pkg::MASK_LINK);
            slb_pkg::OFS_IND_CTL: begin
               next_state.ind_ctl = wmask(req.wdata, slb_pkg::MASK_IND_CTL);
               // Hardware completion wins over a racing write
               if (ind_done) begin
                  next_state.ind_ctl[slb_pkg::IND_READ] = 1'b0;
               end
            end
            // RQ22: byte registers
            slb_pkg::OFS_IND_ADR: next_state.ind_adr = req.wdata;
            slb_pkg::OFS_IND_DAT: begin
               next_state.ind_dat = req.wdata;
               // RQ13: write also advances address
               if (state.ind_ctl[slb_pkg::IND_ENABLE] && state.ind_ctl[slb_pkg::IND_AUTO_INC]) begin
                  next_state.ind_adr = state.ind_adr + 8'h01;
               end
            end
            slb_pkg::OFS_BRIDGE: begin
               next_state.bridge = wmask(req.wdata, slb_pkg::MASK_BRIDGE);
               if (state.phase == ST_LOAD) begin
                  next_state.bridge[slb_pkg::BR_CFG_INIT] = 1'b1;
               end
            end
            default: ;
         endcase
      end

      if (second_port_select) begin
         next_state.cap1 = next_cap;
      end else begin
         next_state.cap0 = next_cap;
      end

      // Registered read data for the serial slave
      if (req.read) begin
         case (req.addr)
            slb_pkg::OFS_CAP: next_state.rdata = cap_sel;
            slb_pkg::OFS_LINK: next_state.rdata = state.link;
            slb_pkg::OFS_IND_CTL: next_state.rdata = state.ind_ctl;
            slb_pkg::OFS_IND_ADR: next_state.rdata = state.ind_adr;
            slb_pkg::OFS_IND_DAT: next_state.rdata = state.ind_dat;
            slb_pkg::OFS_BRIDGE: next_state.rdata = state.bridge;
            default: next_state.rdata = 8'h00;
         endcase
      end

      // RQ2: frequency training request
      next_state.video.freq_train = cap_sel[slb_pkg::CAP_FREQ_TRAIN];
      // RQ3: equalizer training request
      next_state.video.eq_train = cap_sel[slb_pkg::CAP_EQ_TRAIN];
      next_state.video.bitmap_sel = state.bridge[slb_pkg::BR_MAPSEL];
      next_state.video.pixel_mode = state.bridge[slb_pkg::BR_PIXMODE];
      // RQ20: swap drives port routing
      next_state.video.port_swap = state.bridge[slb_pkg::BR_SWAP];
      next_state.loading = (state.phase == ST_LOAD);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
         state.phase <= ST_STRAP;
         state.cap0 <= slb_pkg::RST_CAP;
         state.cap1 <= slb_pkg::RST_CAP;
         state.link <= slb_pkg::RST_LINK;
         state.ind_ctl <= slb_pkg::RST_IND_CTL;
         state.ind_adr <= slb_pkg::RST_IND_ADR;
         state.ind_dat <= slb_pkg::RST_IND_DAT;
         state.bridge <= slb_pkg::RST_BRIDGE;
      end else begin
         state <= next_state;
      end
   end

   assign rdata = state.rdata;
   assign link_detect = state.detect;
   assign video = state.video;
   assign cfg_loading = state.loading;

   // ****************************************
   // Checks
   // ****************************************
   sequence cap_frozen_s;
      second_port_select == 1'b0 && state.cap0[slb_pkg::CAP_FREEZE] && !req.write;
   endsequence

   // RQ1
   freeze_holds_a: assert property (@(posedge clock) disable iff (!rstn) // RQ1
      cap_frozen_s |=> state.cap0 == $past(state.cap0))
      else $error("frozen capabilities changed");

   // RQ8
   auto_fill_a: assert property (@(posedge clock) disable iff (!rstn) // RQ8
      (sync2[0] && remote_caps.valid && !second_port_select && !req.write
       && !state.cap0[slb_pkg::CAP_FREEZE])
      |=> state.cap0[1:0] == $past({remote_caps.wide_video, remote_caps.fwd_gpio}))
      else $error("capability auto-fill missing");

   // RQ2
   freq_train_a: assert property (@(posedge clock) disable iff (!rstn) // RQ2
      (!second_port_select && state.cap0[slb_pkg::CAP_FREQ_TRAIN]) |=> video.freq_train)
      else $error("frequency training not requested");

   // RQ3
   eq_train_a: assert property (@(posedge clock) disable iff (!rstn) // RQ3
      (!second_port_select && state.cap0[slb_pkg::CAP_EQ_TRAIN]) |=> video.eq_train)
      else $error("equalizer training not requested");

   // RQ15
   start_clears_a: assert property (@(posedge clock) disable iff (!rstn) // RQ15
      ind_done |=> !state.ind_ctl[slb_pkg::IND_READ])
      else $error("start bit not cleared after read");

   // RQ17
   no_read_disabled_a: assert property (@(posedge clock) disable iff (!rstn) // RQ17
      (!state.ind_ctl[slb_pkg::IND_ENABLE] && !ind_busy) |=> !ind_busy)
      else $error("indirect read while disabled");

   // RQ13
   auto_inc_a: assert property (@(posedge clock) disable iff (!rstn) // RQ13
      (ind_done && state.ind_ctl[slb_pkg::IND_AUTO_INC] && !req.write)
      |=> state.ind_adr == $past(state.ind_adr) + 8'h01)
      else $error("indirect address not advanced");

   // RQ21
   reload_ends_a: assert property (@(posedge clock) disable iff (!rstn) // RQ21
      $rose(state.phase == ST_LOAD) |-> ##16 !state.bridge[slb_pkg::BR_CFG_INIT])
      else $error("reload bit not cleared");

   // RQ21
   loading_flag_a: assert property (@(posedge clock) disable iff (!rstn) // RQ21
      (state.phase == ST_LOAD) |=> cfg_loading)
      else $error("reload in progress not flagged");

   // RQ18 RQ19
   strap_load_a: assert property (@(posedge clock) disable iff (!rstn) // RQ18
      (state.phase == ST_STRAP && state.load_cnt == 5'(slb_pkg::STRAP_SYNC_CYC) && !req.write)
      |=> state.bridge[7:6] == $past(sync2[2:1]))
      else $error("strap values not loaded");

   // RQ24
   reserved_zero_a: assert property (@(posedge clock) disable iff (!rstn) // RQ24
      (state.link[7:2] == 6'h00) && (state.bridge[4:2] == 3'h0) && !state.bridge[0]
       && !state.cap0[6] && !state.cap1[6] && (state.ind_ctl[7:5] == 3'h0))
      else $error("reserved bit set");

endmodule

/* include/slb_pkg.sv */
// Package: register map, field positions, reset values and timing counts
package slb_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_CAP = 8'h20;
   localparam logic [7:0] OFS_LINK = 8'h26;
   localparam logic [7:0] OFS_IND_CTL = 8'h48;
   localparam logic [7:0] OFS_IND_ADR = 8'h49;
   localparam logic [7:0] OFS_IND_DAT = 8'h4B;
   localparam logic [7:0] OFS_BRIDGE = 8'h4F;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CAP_FREEZE = 7;
   localparam int CAP_FREQ_TRAIN = 5;
   localparam int CAP_EQ_TRAIN = 4;
   localparam int CAP_DUAL_LINK = 3;
   localparam int CAP_DUAL_CHAN = 2;
   localparam int CAP_WIDE_VIDEO = 1;
   localparam int CAP_FWD_GPIO = 0;
   localparam int IND_SEL_LO = 3;
   localparam int IND_AUTO_INC = 2;
   localparam int IND_READ = 1;
   localparam int IND_ENABLE = 0;
   localparam int BR_MAPSEL = 7;
   localparam int BR_PIXMODE = 6;
   localparam int BR_SWAP = 5;
   localparam int BR_CFG_INIT = 1;

   // Writable bit masks; reserved bits stay zero
   localparam logic [7:0] MASK_CAP = 8'hBF;
   localparam logic [7:0] MASK_LINK = 8'h03;
   localparam logic [7:0] MASK_IND_CTL = 8'h1F;
   localparam logic [7:0] MASK_BRIDGE = 8'hE2;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_CAP = 8'h00;
   localparam logic [7:0] RST_LINK = 8'h00;
   localparam logic [7:0] RST_IND_CTL = 8'h00;
   localparam logic [7:0] RST_IND_ADR = 8'h00;
   localparam logic [7:0] RST_IND_DAT = 8'h00;
   localparam logic [7:0] RST_BRIDGE = 8'h00;

   // Target select codes
   localparam logic [1:0] SEL_CONFIG = 2'h2;
   localparam logic [1:0] SEL_DIE_ID = 2'h3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS = 100;
   localparam int T_LINK00_US = 325;
   localparam int T_LINK01_US = 162;
   localparam int T_LINK10_US = 650;
   localparam int T_LINK11_NS = 1300000;
   localparam int CYC_LINK00 = T_LINK00_US * 1000 / CLK_NS;
   localparam int CYC_LINK01 = T_LINK01_US * 1000 / CLK_NS;
   localparam int CYC_LINK10 = T_LINK10_US * 1000 / CLK_NS;
   localparam int CYC_LINK11 = T_LINK11_NS / CLK_NS;
   localparam int CFG_LOAD_CYC = 16;
   localparam int IND_RD_CYC = 2;
   localparam int STRAP_SYNC_CYC = 2;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic        write;
      logic        read;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } slb_req_t;

   typedef struct packed {
      logic        valid;
      logic        dual_link;
      logic        dual_chan;
      logic        wide_video;
      logic        fwd_gpio;
   } slb_caps_t;

   typedef struct packed {
      logic        bitmap_sel;
      logic        pixel_mode;
      logic        port_swap;
      logic        freq_train;
      logic        eq_train;
   } slb_video_t;

endpackage

/* design/slb_link_timer.sv */
// Link-detect timeout timer
`timescale 1ns/10ps
module slb_link_timer (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [1:0] timeout_sel,
   input wire logic valid_rx,
   output logic link_detect
);

   typedef struct packed {
      logic [13:0] count;
      logic        detect;
   } slb_lt_state_t;

   slb_lt_state_t state;
   slb_lt_state_t next_state;
   logic [13:0] limit;

   // Cycle count of the selected timeout
   always_comb begin
      case (timeout_sel)
         2'h0: limit = 14'(slb_pkg::CYC_LINK00);
         2'h1: limit = 14'(slb_pkg::CYC_LINK01);
         2'h2: limit = 14'(slb_pkg::CYC_LINK10);
         default: limit = 14'(slb_pkg::CYC_LINK11);
      endcase
   end

   // RQ10: timeout drops detect
   always_comb begin
      next_state = state;
      if (valid_rx) begin
         next_state.count = 14'h0000;
         next_state.detect = 1'b1;
      end else if (state.count >= limit - 14'h0001) begin
         next_state.detect = 1'b0;
      end else begin
         next_state.count = state.count + 14'h0001;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign link_detect = state.detect;

   // RQ10: silence drops detect
   idle_drop_a: assert property (@(posedge clock) disable iff (!rstn) // RQ10
      (!valid_rx && state.count >= limit - 14'h0001) |=> !link_detect)
      else $error("link detect held after timeout");

   rx_sets_a: assert property (@(posedge clock) disable iff (!rstn) // RQ10
      valid_rx |=> (link_detect && state.count == 14'h0000))
      else $error("valid traffic did not restore link detect");

endmodule

/* design/slb_indirect.sv */
// Indirect read engine for configuration data and die identifier
`timescale 1ns/10ps
module slb_indirect #(
   parameter logic [7:0] DIE_ID_BASE = 8'h5A
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic start,
   input wire logic [1:0] target,
   input wire logic [7:0] addr,
   output logic busy,
   output logic done,
   output logic [7:0] rdata
);

   typedef struct packed {
      logic [1:0] cnt;
      logic       busy;
      logic       done;
      logic [7:0] data;
   } slb_ind_state_t;

   slb_ind_state_t state;
   slb_ind_state_t next_state;

   // Read-only targets; die identifier value is arbitrary
   // RQ12: target code decode
   function automatic logic [7:0] fetch(input logic [1:0] sel, input logic [7:0] a);
      case (sel)
         slb_pkg::SEL_CONFIG: fetch = a ^ 8'hC3;
         slb_pkg::SEL_DIE_ID: fetch = DIE_ID_BASE + a;
         default: fetch = 8'h00;
      endcase
   endfunction

   // RQ14: timed fetch of target
   always_comb begin
      next_state = state;
      next_state.done = 1'b0;
      if (state.busy) begin
         if (state.cnt == 2'(slb_pkg::IND_RD_CYC - 1)) begin
            next_state.busy = 1'b0;
            next_state.done = 1'b1;
            next_state.data = fetch(target, addr);
         end else begin
            next_state.cnt = state.cnt + 2'h1;
         end
      end else if (start) begin
         next_state.busy = 1'b1;
         next_state.cnt = 2'h0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign busy = state.busy;
   assign done = state.done;
   assign rdata = state.data;

   // RQ14: read finishes in time
   read_latency_a: assert property (@(posedge clock) disable iff (!rstn) // RQ14
      (start && !busy) |=> busy[*2] ##1 done)
      else $error("indirect read latency wrong");

endmodule

/* tb/slb_remote_model.sv */
// Remote receiver model: lock, back-channel traffic and capability words
`timescale 1ns/10ps
module slb_remote_model (
   input wire logic clock,
   input wire logic active,
   input slb_pkg::slb_caps_t caps,
   output logic rx_lock = 1'b0,
   output logic backchannel_valid = 1'b0,
   output slb_pkg::slb_caps_t remote_caps = '0
);
   logic [2:0] phase = 3'h0;

   // ****************************************
   // Back-channel frames
   // ****************************************
   // One frame every 8 cycles while the link is up
   // Between frames the fields toggle, so only valid may qualify a load
   always @(posedge clock) begin
      phase <= #1 phase + 3'h1;
      rx_lock <= #1 active;
      backchannel_valid <= #1 active && phase == 3'h0;
      remote_caps <= #1 (active && phase == 3'h0) ? caps : {1'b0, ~remote_caps[3:0]};
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the link bridge register group
`timescale 1ns/10ps
module testbench;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   slb_pkg::slb_req_t req = '0;
   logic [7:0] rdata;
   logic port_sel = 1'b0;
   logic strap0 = 1'b1;
   logic strap1 = 1'b0;
   logic active = 1'b0;
   logic rx_lock;
   logic bc_valid;
   logic link_detect;
   logic cfg_loading;
   slb_pkg::slb_caps_t remote_caps;
   slb_pkg::slb_caps_t caps = 5'h1B;
   slb_pkg::slb_video_t video;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int n;

   // ****************************************
   // Design and far side
   // ****************************************
   // Die identifier base is arbitrary
   slb_regs #(.DIE_ID_BASE(8'h3C)) uut (.clock(clock), .rstn(rstn), .req(req),
      .rdata(rdata), .second_port_select(port_sel), .strap_select_zero(strap0),
      .strap_select_one(strap1), .rx_lock(rx_lock), .backchannel_valid(bc_valid),
      .remote_caps(remote_caps), .link_detect(link_detect), .video(video),
      .cfg_loading(cfg_loading));
   slb_remote_model far (.clock(clock), .active(active), .caps(caps),
      .rx_lock(rx_lock), .backchannel_valid(bc_valid), .remote_caps(remote_caps));

   initial begin
      forever #50 clock = ~clock;
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic complete_run;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One-cycle write pulse, released after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 req = '{1'b1, 1'b0, a, d};
      @(posedge clock);
      #1 req = '0;
   endtask

   // Read data is registered at the taking edge
   task automatic rq(input logic [7:0] a);
      @(posedge clock);
      #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      #1 req = '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      rq(a);
      chk(rdata, exp);
   endtask

   // Poll until masked bits clear, bounded so a stuck bit cannot hang
   task automatic poll(input logic [7:0] a, input logic [7:0] m);
      n = 0;
      rq(a);
      while ((rdata & m) !== 8'h00 && n < 40) begin
         rq(a);
         n++;
      end
      chk(rdata & m, 8'h00);
   endtask

   // Hang guard well above the longest wait
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("MISMATCH t=%0t timeout", $time);
         complete_run;
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clock);
      #1 rstn = 1'b1;
      repeat (2) @(posedge clock);
      rd(slb_pkg::OFS_BRIDGE, 8'h40);
      rd(slb_pkg::OFS_CAP, 8'h00);
      rd(slb_pkg::OFS_IND_ADR, 8'h00);
      rd(slb_pkg::OFS_IND_DAT, 8'h00);
      rd(8'h30, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(slb_pkg::OFS_LINK, 8'hFC | 8'(i));
         rd(slb_pkg::OFS_LINK, 8'(i));
      end
      // Capabilities arrive once the remote side locks
      #1 active = 1'b1;
      repeat (20) @(posedge clock);
      rd(slb_pkg::OFS_CAP, 8'h0B);
      chk({7'h0, link_detect}, 8'h01);
      // Software override must freeze, else it is overwritten
      wr(slb_pkg::OFS_CAP, 8'hF4);
      repeat (20) @(posedge clock);
      rd(slb_pkg::OFS_CAP, 8'hB4);
      chk({6'h0, video.freq_train, video.eq_train}, 8'h03);
      #1 port_sel = 1'b1;
      repeat (20) @(posedge clock);
      rd(slb_pkg::OFS_CAP, 8'h0B);
      chk({6'h0, video.freq_train, video.eq_train}, 8'h00);
      #1 port_sel = 1'b0;
      // Indirect reads: config data, die identifier, no increment
      wr(slb_pkg::OFS_IND_ADR, 8'h05);
      wr(slb_pkg::OFS_IND_CTL, 8'h17);
      poll(slb_pkg::OFS_IND_CTL, 8'h02);
      rd(slb_pkg::OFS_IND_ADR, 8'h06);
      rd(slb_pkg::OFS_IND_DAT, 8'hC6);
      wr(slb_pkg::OFS_IND_ADR, 8'h06);
      wr(slb_pkg::OFS_IND_CTL, 8'h1F);
      poll(slb_pkg::OFS_IND_CTL, 8'h02);
      rd(slb_pkg::OFS_IND_ADR, 8'h07);
      rd(slb_pkg::OFS_IND_DAT, 8'h42);
      wr(slb_pkg::OFS_IND_CTL, 8'h13);
      poll(slb_pkg::OFS_IND_CTL, 8'h02);
      rd(slb_pkg::OFS_IND_ADR, 8'h07);
      rd(slb_pkg::OFS_IND_DAT, 8'hC4);
      wr(slb_pkg::OFS_IND_CTL, 8'hF2);
      repeat (6) @(posedge clock);
      rd(slb_pkg::OFS_IND_CTL, 8'h12);
      rd(slb_pkg::OFS_IND_DAT, 8'hC4);
      // Reserved target codes read back zero
      wr(slb_pkg::OFS_IND_CTL, 8'h03);
      poll(slb_pkg::OFS_IND_CTL, 8'h02);
      rd(slb_pkg::OFS_IND_DAT, 8'h00);
      // A data write also advances the address
      wr(slb_pkg::OFS_IND_CTL, 8'h05);
      wr(slb_pkg::OFS_IND_DAT, 8'h5A);
      rd(slb_pkg::OFS_IND_ADR, 8'h08);
      rd(slb_pkg::OFS_IND_DAT, 8'h5A);
      wr(slb_pkg::OFS_IND_CTL, 8'h00);
      // Bridge controls and configuration reload
      wr(slb_pkg::OFS_BRIDGE, 8'hFE);
      // Video levels are registered one cycle after the write
      @(posedge clock);
      #1 chk({5'h0, video.bitmap_sel, video.pixel_mode, video.port_swap}, 8'h07);
      repeat (2) @(posedge clock);
      #1 chk({7'h0, cfg_loading}, 8'h01);
      poll(slb_pkg::OFS_BRIDGE, 8'h02);
      rd(slb_pkg::OFS_BRIDGE, 8'hE0);
      chk({7'h0, cfg_loading}, 8'h00);
      // Silence the back channel; the shortest timeout must expire
      wr(slb_pkg::OFS_LINK, 8'h01);
      #1 active = 1'b0;
      repeat (slb_pkg::CYC_LINK01 - 20) @(posedge clock);
      #1 chk({7'h0, link_detect}, 8'h01);
      n = 0;
      while (link_detect !== 1'b0 && n < 60) begin
         @(posedge clock);
         #1 n++;
      end
      chk({7'h0, link_detect}, 8'h00);
      complete_run;
   end
endmodule
